// ### design/bmsc_pkg.sv
package bmsc_pkg;
  // ==========================================================
  // register map (apb byte addresses)
  localparam logic [15:0] BMSC_ADDR_EMU_STATUS = 16'hfe0a;
  localparam logic [15:0] BMSC_ADDR_SYSCFG     = 16'hfe10;
  localparam logic [15:0] BMSC_ADDR_BUSCFG0    = 16'hfe14;
  localparam logic [15:0] BMSC_ADDR_BOOTSTAT   = 16'hfe18;
  localparam logic [15:0] BMSC_ADDR_CONTROL    = 16'hfe1c;
  localparam logic [15:0] BMSC_ADDR_FLASH_BASE = 16'hfe20;

  // ==========================================================
  // strap codes
  localparam logic [1:0] BMSC_STRAP_ALT    = 2'b01;
  localparam logic [1:0] BMSC_STRAP_BSL    = 2'b10;
  localparam logic [1:0] BMSC_STRAP_NORMAL = 2'b11;
  localparam int BMSC_STRAP_LSB = 4;

  // ==========================================================
  // field positions
  localparam int BMSC_ALT_FLAG_BIT  = 5;
  localparam int BMSC_ROM_EN_BIT    = 10;
  localparam int BMSC_BYTE_DIS_BIT  = 9;
  localparam int BMSC_BUS_ACT_BIT   = 10;
  localparam int BMSC_ALE_LONG_BIT  = 9;
  localparam int BMSC_BUS_TYPE_FIELD_LSB      = 6;
  localparam int BMSC_BYTE_HIGH_DISABLE_BIT_STRAP  = 7;
  localparam int BMSC_BUS_TYPE_FIELD_STRAP    = 6;

  // ==========================================================
  // flash word addresses (24-bit)
  localparam logic [23:0] BMSC_USR_OP0 = 24'h00_0000;
  localparam logic [23:0] BMSC_USR_OP1 = 24'h00_1ffc;
  localparam logic [23:0] BMSC_USR_REF = 24'h00_1ffe;
  localparam logic [23:0] BMSC_ALT_OP0 = 24'h09_0000;
  localparam logic [23:0] BMSC_ALT_OP1 = 24'h09_1ffc;
  localparam logic [23:0] BMSC_ALT_REF = 24'h09_1ffe;

  // ==========================================================
  // reset values and words
  localparam logic [15:0] BMSC_ZERO16 = 16'h0000;
  localparam logic [15:0] BMSC_ONES16 = 16'hffff;
  localparam logic [7:0]  BMSC_SEL_BOTH = 8'h03;
  localparam logic [7:0]  BMSC_SEL_UART = 8'h01;
  localparam logic [7:0]  BMSC_SEL_CAN  = 8'h02;

  // ==========================================================
  // boot outcome codes
  typedef enum logic [2:0]
  {
    BMSC_OUT_NONE      = 3'b000,
    BMSC_OUT_NORMAL    = 3'b001,
    BMSC_OUT_BSL       = 3'b010,
    BMSC_OUT_USER_SIG  = 3'b011,
    BMSC_OUT_ALT_SIG   = 3'b100,
    BMSC_OUT_SELECTIVE = 3'b101,
    BMSC_OUT_LOOP      = 3'b110,
    BMSC_OUT_TEST      = 3'b111
  } bmsc_outcome_e;

  typedef enum logic [3:0]
  {
    BMSC_ST_IDLE    = 4'b0000,
    BMSC_ST_DECODE  = 4'b0001,
    BMSC_ST_RD      = 4'b0010,
    BMSC_ST_WAIT    = 4'b0011,
    BMSC_ST_EVAL    = 4'b0100,
    BMSC_ST_DONE    = 4'b0101
  } bmsc_state_e;
endpackage

// ### design/bmsc_sig_calc.sv
`timescale 1ns/1ps
module bmsc_sig_calc
  import bmsc_pkg::*;
(
  // operands
  input  wire logic [15:0] op0,
  input  wire logic [15:0] op1,
  input  wire logic [15:0] ref_word,
  // result
  output logic             pass
);
  logic [15:0] sum;
  logic [15:0] sig;

  // ==========================================================
  // signature
  assign sum = op0 + op1;
  assign sig = {sum[15:8], ~sum[7:0]};
  assign pass = (sig == ref_word);
endmodule

// ### design/bmsc_top.sv
// What this block does
// - strap 01 enters alternate boot, checks signatures
// - strap 11 gives ordinary reset start-up
// - strap 10 starts loader, clears alternate indicator
// - other straps select internal test modes
// - watchdog off in alternate boot; reset soft
// - bootstrap forces rom enable; byte-disable from strap
// - external access high clears bus config zero
// - access low sets active, lengthen, bus type
// - alternate boot left only by reset
// - user signature words at 000000,001ffc,001ffe
// - alternate signature words at 090000,091ffc,091ffe
// - pass when sum with inverted low byte matches
// - read-only alternate flag bit 5 at fe0a
// - no signature: reread, zeros or ones go loader
// - low byte bits pick uart and can
// - 03,01,02 poll; other values loop forever
// - straps sampled from port zero at reset rise
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module bmsc_top
  import bmsc_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        reset_input_pin,
  input  wire logic [7:0]  boot_strap_port_low,
  input  wire logic        external_access_pin,
  input  wire logic        soft_reset_req,
  input  wire logic        watchdog_reset_req,
  // flash read port
  output logic             flash_rd,
  output logic [23:0]      flash_addr,
  input  wire logic        flash_ack,
  input  wire logic [15:0] flash_data,
  // boot results
  output logic             boot_done,
  output logic [2:0]       boot_outcome,
  output logic [23:0]      start_addr,
  output logic             watchdog_enable,
  output logic             poll_uart,
  output logic             poll_can,
  output logic             test_mode,
  output logic             alternate_boot_flag,
  output logic             soft_reset_out,
  output logic [15:0]      system_configuration_register,
  output logic [15:0]      bus_configuration_zero
);
  // ==========================================================
  // pin synchronisers
  logic [1:0]  rst_pin_sync_r;
  logic [7:0]  strap_s1_r;
  logic [7:0]  strap_s2_r;
  logic [1:0]  ea_sync_r;
  logic        rst_pin_prev_r;
  logic        rst_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_pin_sync_r <= 2'b00;
      strap_s1_r     <= 8'h00;
      strap_s2_r     <= 8'h00;
      ea_sync_r      <= 2'b00;
      rst_pin_prev_r <= 1'b0;
    end
    else
    begin
      rst_pin_sync_r <= {rst_pin_sync_r[0], reset_input_pin};
      strap_s1_r     <= boot_strap_port_low;
      strap_s2_r     <= strap_s1_r;
      ea_sync_r      <= {ea_sync_r[0], external_access_pin};
      rst_pin_prev_r <= rst_pin_sync_r[1];
    end
  end

  assign rst_rise = rst_pin_sync_r[1] & ~rst_pin_prev_r;

  // ==========================================================
  // strap latch; held until next reset pin rise or presetn
  logic [1:0] strap_r;
  logic [1:0] width_strap_r;
  logic       ea_low_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_r       <= BMSC_STRAP_NORMAL;
      width_strap_r <= 2'b00;
      ea_low_r      <= 1'b0;
    end
    else if (rst_rise)
    begin
      strap_r       <= strap_s2_r[BMSC_STRAP_LSB +: 2];
      width_strap_r <= strap_s2_r[BMSC_BUS_TYPE_FIELD_STRAP +: 2];
      ea_low_r      <= ~ea_sync_r[1];
    end
  end

  // ==========================================================
  // sequencer
  bmsc_state_e   state_r;
  logic [1:0]    step_r;
  logic          alt_pass_r;
  logic [15:0]   op0_r;
  logic [15:0]   op1_r;
  logic          sig_pass;
  logic          soft_rst;
  logic [7:0]    sel_lo;

  assign soft_rst = soft_reset_req | (watchdog_reset_req & alternate_boot_flag);
  assign sel_lo   = flash_data[7:0];

  bmsc_sig_calc u_sig
  (
    .op0      (op0_r),
    .op1      (op1_r),
    .ref_word (flash_data),
    .pass     (sig_pass)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r      <= BMSC_ST_IDLE;
      step_r       <= 2'b00;
      alt_pass_r   <= 1'b0;
      op0_r        <= BMSC_ZERO16;
      op1_r        <= BMSC_ZERO16;
      flash_rd     <= 1'b0;
      flash_addr   <= BMSC_USR_OP0;
      boot_done    <= 1'b0;
      boot_outcome <= BMSC_OUT_NONE;
      start_addr   <= BMSC_USR_OP0;
      poll_uart    <= 1'b0;
      poll_can     <= 1'b0;
      test_mode    <= 1'b0;
    end
    else if (rst_rise || soft_rst)
    begin
      // a reset restarts decoding; the only exit from alternate boot
      state_r      <= BMSC_ST_DECODE;
      boot_done    <= 1'b0;
      boot_outcome <= BMSC_OUT_NONE;
      flash_rd     <= 1'b0;
      poll_uart    <= 1'b0;
      poll_can     <= 1'b0;
      test_mode    <= 1'b0;
    end
    else
    begin
      case (state_r)
        BMSC_ST_IDLE:
        begin
          state_r <= BMSC_ST_IDLE;
        end
        BMSC_ST_DECODE:
        begin
          case (strap_r)
            BMSC_STRAP_ALT:
            begin
              state_r    <= BMSC_ST_RD;
              step_r     <= 2'd0;
              alt_pass_r <= 1'b0;
              flash_addr <= BMSC_USR_OP0;
              flash_rd   <= 1'b1;
            end
            BMSC_STRAP_NORMAL:
            begin
              state_r      <= BMSC_ST_DONE;
              boot_outcome <= BMSC_OUT_NORMAL;
              start_addr   <= BMSC_USR_OP0;
              boot_done    <= 1'b1;
            end
            BMSC_STRAP_BSL:
            begin
              state_r      <= BMSC_ST_DONE;
              boot_outcome <= BMSC_OUT_BSL;
              boot_done    <= 1'b1;
            end
            default:
            begin
              state_r      <= BMSC_ST_DONE;
              boot_outcome <= BMSC_OUT_TEST;
              test_mode    <= 1'b1;
              boot_done    <= 1'b1;
            end
          endcase
        end
        BMSC_ST_RD:
        begin
          // request held until acknowledged
          if (flash_ack)
          begin
            flash_rd <= 1'b0;
            state_r  <= BMSC_ST_EVAL;
          end
        end
        BMSC_ST_EVAL:
        begin
          state_r  <= BMSC_ST_RD;
          flash_rd <= 1'b1;
          case (step_r)
            2'd0:
            begin
              op0_r      <= flash_data;
              step_r     <= 2'd1;
              flash_addr <= alt_pass_r ? BMSC_ALT_OP1 : BMSC_USR_OP1;
            end
            2'd1:
            begin
              op1_r      <= flash_data;
              step_r     <= 2'd2;
              flash_addr <= alt_pass_r ? BMSC_ALT_REF : BMSC_USR_REF;
            end
            2'd2:
            begin
              if (sig_pass)
              begin
                state_r      <= BMSC_ST_DONE;
                flash_rd     <= 1'b0;
                boot_done    <= 1'b1;
                boot_outcome <= alt_pass_r ? BMSC_OUT_ALT_SIG : BMSC_OUT_USER_SIG;
                start_addr   <= alt_pass_r ? BMSC_ALT_OP0 : BMSC_USR_OP0;
              end
              else if (!alt_pass_r)
              begin
                alt_pass_r <= 1'b1;
                step_r     <= 2'd0;
                flash_addr <= BMSC_ALT_OP0;
              end
              else
              begin
                step_r     <= 2'd3;
                flash_addr <= BMSC_USR_OP1;
              end
            end
            default:
            begin
              state_r   <= BMSC_ST_DONE;
              flash_rd  <= 1'b0;
              boot_done <= 1'b1;
              if (flash_data == BMSC_ZERO16 || flash_data == BMSC_ONES16)
              begin
                boot_outcome <= BMSC_OUT_BSL;
              end
              else if (sel_lo == BMSC_SEL_BOTH || sel_lo == BMSC_SEL_UART ||
                       sel_lo == BMSC_SEL_CAN)
              begin
                boot_outcome <= BMSC_OUT_SELECTIVE;
                poll_uart    <= sel_lo[0];
                poll_can     <= sel_lo[1];
              end
              else
              begin
                boot_outcome <= BMSC_OUT_LOOP;
              end
            end
          endcase
        end
        BMSC_ST_DONE:
        begin
          state_r <= BMSC_ST_DONE;
        end
        default:
        begin
          state_r <= BMSC_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // alternate flag, watchdog, configuration
  logic bootstrap_mode;
  assign bootstrap_mode = (strap_r == BMSC_STRAP_ALT) || (strap_r == BMSC_STRAP_BSL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alternate_boot_flag           <= 1'b0;
      watchdog_enable               <= 1'b0;
      soft_reset_out                <= 1'b0;
      system_configuration_register <= BMSC_ZERO16;
      bus_configuration_zero        <= BMSC_ZERO16;
    end
    else
    begin
      soft_reset_out <= soft_rst;
      if (rst_rise || soft_rst)
      begin
        alternate_boot_flag <= 1'b0;
        watchdog_enable     <= 1'b0;
      end
      else if (state_r == BMSC_ST_DECODE)
      begin
        // bsl strap clears the indicator, alt strap sets it
        alternate_boot_flag <= (strap_r == BMSC_STRAP_ALT);
        watchdog_enable     <= !bootstrap_mode;
        system_configuration_register <= BMSC_ZERO16;
        system_configuration_register[BMSC_ROM_EN_BIT]   <= bootstrap_mode;
        system_configuration_register[BMSC_BYTE_DIS_BIT] <= width_strap_r[1];
        if (!ea_low_r)
        begin
          bus_configuration_zero <= BMSC_ZERO16;
        end
        else
        begin
          bus_configuration_zero <= BMSC_ZERO16;
          bus_configuration_zero[BMSC_BUS_ACT_BIT]   <= 1'b1;
          bus_configuration_zero[BMSC_ALE_LONG_BIT]  <= 1'b1;
          bus_configuration_zero[BMSC_BUS_TYPE_FIELD_LSB +: 2] <= width_strap_r;
        end
      end
    end
  end

  // ==========================================================
  // apb slave: zero wait, all registers read-only
  logic [31:0] rd_mux;
  logic        addr_ok;

  always_comb
  begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      BMSC_ADDR_EMU_STATUS: rd_mux[BMSC_ALT_FLAG_BIT] = alternate_boot_flag;
      BMSC_ADDR_SYSCFG:     rd_mux[15:0] = system_configuration_register;
      BMSC_ADDR_BUSCFG0:    rd_mux[15:0] = bus_configuration_zero;
      BMSC_ADDR_BOOTSTAT:   rd_mux[7:0]  = {boot_done, test_mode, poll_can, poll_uart,
                                            1'b0, boot_outcome};
      BMSC_ADDR_CONTROL:    rd_mux[1:0]  = strap_r;
      default:              addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      // writes are refused: every register here is read-only
      pslverr <= psel & ~penable & (~addr_ok | pwrite);
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// ### verification/bmsc_flash_model.sv
`timescale 1ns/1ps
module bmsc_flash_model
(
  // clock
  input  wire logic        pclk,
  // read port
  input  wire logic        flash_rd,
  input  wire logic [23:0] flash_addr,
  output logic             flash_ack,
  output logic [15:0]      flash_data
);
  // ====
  // words and answer delay, set by the bench
  logic [15:0] mem [0:5];
  int          lat = 0;
  int          cnt = 0;
  logic        hold_r = 1'b0;
  initial
  begin
    flash_ack = 1'b0;
    flash_data = 16'h0000;
  end
  // user words 0..2, alternate words 3..5
  function automatic int idx(input logic [23:0] a);
    return (a[19] ? 3 : 0) + (a[1] ? 2 : (a[2] ? 1 : 0));
  endfunction
  // released data toggles so a stale word never passes for an answer
  always @(posedge pclk)
  begin
    hold_r <= flash_ack;
    if (flash_rd && !flash_ack && !hold_r && cnt >= lat)
    begin
      cnt        <= 0;
      flash_ack  <= 1'b1;
      flash_data <= mem[idx(flash_addr)];
    end
    else
    begin
      flash_ack <= 1'b0;
      if (flash_rd && !flash_ack && !hold_r)
        cnt <= cnt + 1;
      if (!flash_ack && !hold_r)
        flash_data <= ~flash_data;
    end
  end
endmodule

// ### verification/bmsc_top_chk.sv
`timescale 1ns/1ps
module bmsc_top_chk
  import bmsc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // resets and mode
  input wire logic        soft_reset_req,
  input wire logic        watchdog_reset_req,
  input wire logic        soft_reset_out,
  input wire logic        alternate_boot_flag,
  input wire logic        watchdog_enable,
  input wire logic        external_access_pin,
  input wire logic        reset_input_pin,
  input wire logic        boot_done,
  input wire logic [2:0]  boot_outcome,
  input wire logic [15:0] system_configuration_register,
  input wire logic [15:0] bus_configuration_zero,
  // flash
  input wire logic        flash_rd,
  input wire logic        flash_ack,
  input wire logic [23:0] flash_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // flash handshake
  sequence s_rd_wait; flash_rd && !flash_ack; endsequence
  sequence s_rd_take; flash_rd && flash_ack; endsequence
  property p_flash_hold; s_rd_wait |=> flash_rd && $stable(flash_addr); endproperty
  a_flash_hold: assert property (p_flash_hold)
    else $error("flash request not held");
  property p_flash_drop; s_rd_take |=> !flash_rd; endproperty
  a_flash_drop: assert property (p_flash_drop)
    else $error("flash request kept after ack");
  // ====
  // register bus
  property p_apb_ready; psel && !penable |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no ready in access phase");
  // ====
  // alternate boot
  property p_wdt_off; alternate_boot_flag |-> !watchdog_enable; endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("watchdog on in alternate boot");
  property p_wd_soft; alternate_boot_flag && watchdog_reset_req |=> soft_reset_out; endproperty
  a_wd_soft: assert property (p_wd_soft)
    else $error("watchdog reset not soft");
  // flag may only fall after a soft reset or a reset pin rise
  property p_flag_hold;
    alternate_boot_flag && !soft_reset_req && !watchdog_reset_req && !soft_reset_out
      && !($past(reset_input_pin, 2) && !$past(reset_input_pin, 3))
      |=> alternate_boot_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("alternate flag left without reset");
  // ====
  // configuration
  property p_rom_en;
    boot_done && (boot_outcome == BMSC_OUT_BSL || alternate_boot_flag)
      |-> system_configuration_register[BMSC_ROM_EN_BIT];
  endproperty
  a_rom_en: assert property (p_rom_en)
    else $error("rom enable clear in bootstrap");
  property p_ea_high;
    boot_done && external_access_pin |-> bus_configuration_zero == BMSC_ZERO16;
  endproperty
  a_ea_high: assert property (p_ea_high)
    else $error("bus config not cleared");
  property p_ea_low;
    boot_done && !external_access_pin |-> bus_configuration_zero[BMSC_BUS_ACT_BIT]
      && bus_configuration_zero[BMSC_ALE_LONG_BIT];
  endproperty
  a_ea_low: assert property (p_ea_low)
    else $error("bus active or lengthen clear");
endmodule

bind bmsc_top bmsc_top_chk u_bmsc_top_chk (.pclk, .presetn, .psel, .penable, .pready,
  .soft_reset_req, .watchdog_reset_req, .soft_reset_out, .alternate_boot_flag,
  .watchdog_enable, .external_access_pin, .reset_input_pin, .boot_done, .boot_outcome,
  .system_configuration_register, .bus_configuration_zero, .flash_rd, .flash_ack,
  .flash_addr);

// ### verification/bmsc_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
  end
module bmsc_top_test
  import bmsc_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        reset_input_pin = 1'b0, external_access_pin = 1'b1;
  logic        soft_reset_req = 1'b0, watchdog_reset_req = 1'b0;
  logic [7:0]  boot_strap_port_low = 8'h30;
  logic [31:0] prdata;
  logic [23:0] flash_addr, start_addr;
  logic [15:0] flash_data, system_configuration_register, bus_configuration_zero;
  logic [2:0]  boot_outcome;
  logic        pready, pslverr, flash_rd, flash_ack, boot_done, watchdog_enable;
  logic        poll_uart, poll_can, test_mode, alternate_boot_flag, soft_reset_out;
  int          miscompares = 0, samples_checked = 0;
  bmsc_top u_bmsc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_input_pin, .boot_strap_port_low, .external_access_pin,
    .soft_reset_req, .watchdog_reset_req, .flash_rd, .flash_addr, .flash_ack, .flash_data,
    .boot_done, .boot_outcome, .start_addr, .watchdog_enable, .poll_uart, .poll_can,
    .test_mode, .alternate_boot_flag, .soft_reset_out, .system_configuration_register,
    .bus_configuration_zero);
  bmsc_flash_model u_bmsc_flash_model (.pclk, .flash_rd, .flash_addr, .flash_ack,
    .flash_data);
  always #20 pclk = ~pclk;
  // ====
  // shared tasks
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] sig(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = a + b;
    return {s[15:8], ~s[7:0]};
  endfunction
  task automatic apb(input logic w, input logic [15:0] a, output logic [31:0] d,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hffff_ffff;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count assumed: only the watchdog ends a hung access
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin rises only after presetn so the straps latch on a clean edge
  task automatic boot(input logic [7:0] s, input logic ea, input int lat);
    int n;
    n = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    reset_input_pin <= 1'b0;
    boot_strap_port_low <= s;
    external_access_pin <= ea;
    u_bmsc_flash_model.lat = lat;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    reset_input_pin <= 1'b1;
    while (boot_done !== 1'b1 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("boot_done", 1'b1, boot_done)
  endtask
  task automatic pulse(input logic wd);
    watchdog_reset_req <= wd;
    soft_reset_req <= !wd;
    @(posedge pclk);
    watchdog_reset_req <= 1'b0;
    soft_reset_req <= 1'b0;
    @(posedge pclk);
  endtask
  // ====
  // scenarios
  task automatic t_normal;
    boot(8'h30, 1'b1, 0);
    `CHK("out_normal", BMSC_OUT_NORMAL, boot_outcome)
    `CHK("buscfg_off", BMSC_ZERO16, bus_configuration_zero)
    `CHK("flag_off", 1'b0, alternate_boot_flag)
    `CHK("wdt_on", 1'b1, watchdog_enable)
    pulse(1'b1);
    `CHK("wd_ignored", 1'b0, soft_reset_out)
    pulse(1'b0);
    `CHK("soft_out", 1'b1, soft_reset_out)
  endtask
  task automatic t_bsl(input logic [7:0] s, input logic eb, input logic [1:0] et);
    logic [31:0] d;
    logic e;
    boot(s, 1'b0, 0);
    `CHK("out_bsl", BMSC_OUT_BSL, boot_outcome)
    `CHK("flag_bsl", 1'b0, alternate_boot_flag)
    `CHK("rom_en", 1'b1, system_configuration_register[10])
    `CHK("byte_dis", eb, system_configuration_register[9])
    `CHK("bus_act", 2'b11, bus_configuration_zero[10:9])
    `CHK("bus_type", et, bus_configuration_zero[7:6])
    apb(1'b0, BMSC_ADDR_BUSCFG0, d, e);
    `CHK("buscfg_reg", {21'h00_0000, 2'b11, 1'b0, et, 6'h00}, d)
    `CHK("rd_err", 1'b0, e)
  endtask
  task automatic t_test;
    boot(8'h00, 1'b1, 0);
    `CHK("out_test", BMSC_OUT_TEST, boot_outcome)
    `CHK("test_mode", 1'b1, test_mode)
  endtask
  task automatic t_alt(input logic [15:0] op1, input logic uok, input logic aok,
                       input logic [2:0] eo, input logic eu, input logic ec, input int lat);
    logic [31:0] d;
    logic e;
    u_bmsc_flash_model.mem[0] = 16'h1234;
    u_bmsc_flash_model.mem[1] = op1;
    u_bmsc_flash_model.mem[2] = sig(16'h1234, op1) ^ (uok ? 16'h0000 : 16'h0001);
    u_bmsc_flash_model.mem[3] = 16'h5678;
    u_bmsc_flash_model.mem[4] = 16'h9abc;
    u_bmsc_flash_model.mem[5] = sig(16'h5678, 16'h9abc) ^ (aok ? 16'h0000 : 16'h0100);
    boot(8'h10, 1'b1, lat);
    `CHK("outcome", eo, boot_outcome)
    `CHK("poll_uart", eu, poll_uart)
    `CHK("poll_can", ec, poll_can)
    `CHK("flag_on", 1'b1, alternate_boot_flag)
    `CHK("wdt_off", 1'b0, watchdog_enable)
    if (eo == BMSC_OUT_ALT_SIG)
      `CHK("start_alt", BMSC_ALT_OP0, start_addr)
    if (eo == BMSC_OUT_USER_SIG)
      `CHK("start_usr", BMSC_USR_OP0, start_addr)
    apb(1'b0, BMSC_ADDR_EMU_STATUS, d, e);
    `CHK("flag_reg", 1'b1, d[BMSC_ALT_FLAG_BIT])
  endtask
  task automatic t_exit;
    logic [31:0] d;
    logic e;
    apb(1'b1, BMSC_ADDR_EMU_STATUS, d, e);
    `CHK("wr_err", 1'b1, e)
    apb(1'b0, 16'h0000, d, e);
    `CHK("unmapped_err", 1'b1, e)
    repeat (40) @(posedge pclk);
    `CHK("flag_kept", 1'b1, alternate_boot_flag)
    pulse(1'b1);
    `CHK("wd_soft", 1'b1, soft_reset_out)
    while (boot_done !== 1'b1)
    begin
      @(posedge pclk);
    end
    // a pin-only hardware reset with new straps must leave alternate boot
    reset_input_pin <= 1'b0;
    boot_strap_port_low <= 8'h30;
    repeat (4) @(posedge pclk);
    reset_input_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("hw_exit", 1'b0, alternate_boot_flag)
    `CHK("hw_outcome", BMSC_OUT_NORMAL, boot_outcome)
  endtask
  // ====
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_normal();
    t_bsl(8'ha0, 1'b1, 2'b10);
    t_bsl(8'h60, 1'b0, 2'b01);
    t_test();
    t_alt(16'h00a5, 1'b1, 1'b0, BMSC_OUT_USER_SIG, 1'b0, 1'b0, 0);
    t_exit();
    t_alt(16'h1234, 1'b0, 1'b1, BMSC_OUT_ALT_SIG, 1'b0, 1'b0, 3);
    t_alt(16'h0000, 1'b0, 1'b0, BMSC_OUT_BSL, 1'b0, 1'b0, 0);
    t_alt(16'hffff, 1'b0, 1'b0, BMSC_OUT_BSL, 1'b0, 1'b0, 2);
    t_alt(16'h5503, 1'b0, 1'b0, BMSC_OUT_SELECTIVE, 1'b1, 1'b1, 1);
    t_alt(16'h0001, 1'b0, 1'b0, BMSC_OUT_SELECTIVE, 1'b1, 1'b0, 0);
    t_alt(16'haa02, 1'b0, 1'b0, BMSC_OUT_SELECTIVE, 1'b0, 1'b1, 3);
    t_alt(16'h0004, 1'b0, 1'b0, BMSC_OUT_LOOP, 1'b0, 1'b0, 0);
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
endmodule
